// file: hdl/drc_ctrl.v
/*
  host-side controller for an asynchronous multiplexed-address dram with a
  4-bit data path: power-up wait, dummy cycles, periodic refresh, reads,
  early writes and read-modify-writes driven on the strobe pins.
  assumes the user request port is synchronous to clk_sys and held until ack.
*/
`timescale 1ns/1ps
`include "drc_defines.vh"
module drc_ctrl #(
  parameter POWERUP_CYC = `DRC_POWERUP_CYC, // power-up wait, shortenable
  parameter REF_INTERVAL_CYC = `DRC_REF_INTERVAL_CYC, // refresh spacing
  parameter USE_CBR = 1 // 1: counter refresh, 0: row-only refresh
) (
  input wire clk_sys, // system clock
  input wire reset, // synchronous, active high
  input wire req, // access request, held until ack
  input wire [1:0] req_kind, // 0 read, 1 early write, 2 read-modify-write
  input wire [15:0] req_addr, // row in [15:8], column in [7:0]
  input wire [3:0] req_wdata, // write data
  output reg ack, // one-cycle pulse at access end
  output reg [3:0] rdata, // read data, valid with ack
  output reg ready, // initialization finished
  output reg row_strobe_n, // row strobe, active low
  output reg col_strobe_n, // column strobe, active low
  output reg write_strobe_n, // write strobe, active low
  output reg oe_strobe_n, // output-enable strobe, active low
  output reg [7:0] muxed_address, // multiplexed address
  output reg [3:0] data_pins_wr, // data driven to the pins
  output reg data_pins_oe, // high while driving data pins
  input wire [3:0] data_pins_rd // data sampled from the pins
);
  // ns to whole clock cycles, rounded up and cut to the timer width
  function [17:0] cyc18;
    input [31:0] ns;
    reg [31:0] full;
    begin
      full = `DRC_CYC(ns);
      cyc18 = full[17:0];
    end
  endfunction

  localparam [3:0] ST_PWR = 4'h0, ST_IDLE = 4'h1, ST_RAS = 4'h2, ST_CAS = 4'h3,
    ST_WE = 4'h4, ST_END = 4'h5, ST_PRE = 4'h6, ST_CBR = 4'h7, ST_ROR = 4'h8;
  localparam [17:0] C_RP = cyc18(`DRC_T_RP_NS); // precharge
  localparam [17:0] C_RCD = cyc18(`DRC_ROW_TO_COL_DELAY_NS); // row to column
  localparam [17:0] C_RAS = cyc18(`DRC_T_RAS_NS); // row pulse
  localparam [17:0] C_CSR = cyc18(`DRC_T_CSR_NS); // column setup for cbr
  // read-modify-write: write must trail row fall by the row delay
  localparam [17:0] C_RWD = cyc18(`DRC_ROW_TO_WRITE_DELAY_NS - `DRC_ROW_TO_COL_DELAY_NS);
  localparam [17:0] C_CWD = cyc18(`DRC_COL_TO_WRITE_DELAY_NS);
  localparam [17:0] C_DH = cyc18(`DRC_T_DH_NS);
  localparam [31:0] PWR_FULL = POWERUP_CYC; // power-up wait as a full word
  // the timer holds 18 bits, so the wait is limited to about 1 ms
  localparam [17:0] C_PWR = PWR_FULL[17:0];

  reg [3:0] st_r; // sequencer state
  reg pwr_armed_r; // power-up wait loaded into the timer
  reg [3:0] dummy_r; // dummy cycles issued
  reg [7:0] ref_row_r; // next row for row-only refresh
  reg [8:0] ref_owed_r; // refreshes due but not done
  reg [17:0] ival_r; // refresh interval counter
  reg [1:0] kind_r; // latched access kind
  reg [15:0] addr_r; // latched address
  reg [3:0] wdata_r; // latched write data
  reg tload; // timer reload
  reg [17:0] tcount; // timer reload value
  wire tdone; // timer expired

  drc_tick u_tick (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(tload),
    .count(tcount),
    .done(tdone)
  );

  // larger of two cycle counts; the read-modify-write column phase needs the longer constraint
  function [17:0] max2;
    input [17:0] a;
    input [17:0] b;
    begin
      max2 = (a > b) ? a : b;
    end
  endfunction

  // interval counter: owes one refresh each interval, spread evenly
  always @(posedge clk_sys) begin
    if (reset) begin
      ival_r <= 18'h00000;
    end else if (ival_r >= REF_INTERVAL_CYC - 1) begin
      ival_r <= 18'h00000;
    end else begin
      ival_r <= ival_r + 18'h00001;
    end
  end

  // sequencer: timer reload is combinational from timer expiry, with or without a state change
  always @* begin
    tload = 1'b0;
    tcount = 18'h00001;
    if (!reset && tdone) begin
      tload = 1'b1;
      case (st_r)
        ST_PWR: tcount = pwr_armed_r ? C_RP : C_PWR;
        ST_IDLE: tcount = (ref_owed_r != 9'h000 || !ready) ?
          ((USE_CBR != 0) ? C_CSR : C_RAS) : C_RCD;
        ST_RAS: tcount = (kind_r == 2'h2) ? max2(C_CWD, C_RWD) : C_RAS;
        ST_CAS: tcount = C_DH;
        ST_WE: tcount = C_DH;
        ST_CBR: tcount = C_RAS;
        default: tcount = C_RP;
      endcase
    end
  end

  // main strobe sequencer
  always @(posedge clk_sys) begin
    if (reset) begin
      st_r <= ST_PWR;
      pwr_armed_r <= 1'b0;
      dummy_r <= 4'h0;
      ref_row_r <= 8'h00;
      ref_owed_r <= 9'h000;
      kind_r <= 2'h0;
      addr_r <= 16'h0000;
      wdata_r <= 4'h0;
      ack <= 1'b0;
      rdata <= 4'h0;
      ready <= 1'b0;
      row_strobe_n <= 1'b1;
      col_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      oe_strobe_n <= 1'b1;
      muxed_address <= 8'h00;
      data_pins_wr <= 4'h0;
      data_pins_oe <= 1'b0;
    end else begin
      ack <= 1'b0;
      // owed count: interval tick adds, a finished refresh removes
      if (ival_r >= REF_INTERVAL_CYC - 1 && ready) begin
        if (!(st_r == ST_PRE && tdone && kind_r == 2'h3)) begin
          ref_owed_r <= ref_owed_r + 9'h001;
        end
      end else if (st_r == ST_PRE && tdone && kind_r == 2'h3 && ready) begin
        ref_owed_r <= ref_owed_r - 9'h001;
      end
      case (st_r)
        ST_PWR: begin
          // the expiry right after reset only loads the long wait; the
          // second one ends it, so no strobe moves early
          if (tdone) begin
            if (pwr_armed_r) begin
              st_r <= ST_IDLE;
            end
            pwr_armed_r <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (tdone) begin
            if (!ready || ref_owed_r != 9'h000) begin
              kind_r <= 2'h3;
              if (USE_CBR != 0) begin
                // counter refresh: column falls first, pins ignored
                col_strobe_n <= 1'b0;
                st_r <= ST_CBR;
              end else begin
                // row-only refresh from our own row pointer
                muxed_address <= ref_row_r;
                row_strobe_n <= 1'b0;
                ref_row_r <= ref_row_r + 8'h01;
                st_r <= ST_ROR;
              end
            end else if (req && req_kind != 2'h3) begin
              kind_r <= req_kind;
              addr_r <= req_addr;
              wdata_r <= req_wdata;
              muxed_address <= req_addr[15:8];
              row_strobe_n <= 1'b0;
              // early write: write strobe low before column fall
              write_strobe_n <= (req_kind != 2'h1);
              st_r <= ST_RAS;
            end
          end
        end
        ST_RAS: begin
          // column phase after the row-to-column delay (access governed
          // by the row strobe, column access within it)
          if (tdone) begin
            muxed_address <= addr_r[7:0];
            col_strobe_n <= 1'b0;
            if (kind_r == 2'h1) begin
              // data valid at column fall for early write
              data_pins_wr <= wdata_r;
              data_pins_oe <= 1'b1;
            end else begin
              oe_strobe_n <= 1'b0;
            end
            st_r <= (kind_r == 2'h2) ? ST_WE : ST_CAS;
          end
        end
        ST_CAS: begin
          if (tdone) begin
            if (kind_r == 2'h0) begin
              rdata <= data_pins_rd;
            end
            st_r <= ST_END;
          end
        end
        ST_WE: begin
          // late write after the longer of the column and row delays
          if (tdone) begin
            if (write_strobe_n) begin
              rdata <= data_pins_rd;
              oe_strobe_n <= 1'b1;
              write_strobe_n <= 1'b0;
              // data driven on the same edge that output enable is released
              data_pins_wr <= wdata_r;
              data_pins_oe <= 1'b1;
            end else begin
              st_r <= ST_END;
            end
          end
        end
        ST_CBR: begin
          if (tdone) begin
            row_strobe_n <= 1'b0;
            st_r <= ST_ROR;
          end
        end
        ST_ROR: begin
          if (tdone) begin
            st_r <= ST_END;
          end
        end
        default: begin
          if (st_r == ST_END) begin
            // both strobes rise together: read hold met on either
            row_strobe_n <= 1'b1;
            col_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            oe_strobe_n <= 1'b1;
            data_pins_oe <= 1'b0;
            ack <= (kind_r != 2'h3);
            st_r <= ST_PRE;
          end else if (tdone) begin
            // precharge done; count dummy cycles during init
            if (!ready && kind_r == 2'h3) begin
              if (dummy_r == `DRC_DUMMY_CYCLES - 1) begin
                ready <= 1'b1;
              end
              dummy_r <= dummy_r + 4'h1;
            end
            st_r <= ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// file: hdl/drc_defines.vh
/*
  timing constants and cycle counts for the dram strobe controller.
  assumes a 250 MHz system clock (4 ns period); counts are derived here.
*/
// Behaviour
// - wait 200 us after power before access
// - eight row-only dummy cycles before normal access
// - dummy cycles column-before-row when counter refresh used
// - read hold met at column or row rise
// - write data timed to column or write fall
// - release data before column or output-enable fall
// - refresh all 256 rows every 4 ms
`ifndef DRC_DEFINES_VH
`define DRC_DEFINES_VH

`define DRC_CLK_PERIOD_NS 4
`define DRC_POWERUP_US 200
`define DRC_POWERUP_CYC ((`DRC_POWERUP_US * 1000) / `DRC_CLK_PERIOD_NS)
`define DRC_DUMMY_CYCLES 8
`define DRC_ROWS 256
`define DRC_REF_PERIOD_MS 4
// one refresh per row, spaced so 256 fit in the period (rounded down)
`define DRC_REF_INTERVAL_CYC \
  ((`DRC_REF_PERIOD_MS * 1000000) / (`DRC_ROWS * `DRC_CLK_PERIOD_NS))
// least times in ns, converted by rounding up
`define DRC_T_RP_NS 70
`define DRC_T_RAS_NS 80
`define DRC_ROW_TO_COL_DELAY_NS 25
`define DRC_T_CAS_NS 20
`define DRC_T_CSR_NS 10
`define DRC_T_CHR_NS 20
`define DRC_COL_STROBE_ACCESS_NS 20
`define DRC_T_RAH_NS 12
`define DRC_COL_TO_WRITE_DELAY_NS 50
`define DRC_ROW_TO_WRITE_DELAY_NS 105
`define DRC_ADDR_TO_WRITE_DELAY_NS 65
`define DRC_T_DH_NS 20
`define DRC_CYC(ns) (((ns) + `DRC_CLK_PERIOD_NS - 1) / `DRC_CLK_PERIOD_NS)

`endif

// file: hdl/drc_tick.v
/*
  down-counting interval timer: raises done when a loaded count expires and holds it until reload.
  assumes load and the count value are synchronous to clk_sys.
*/
`timescale 1ns/1ps
module drc_tick (
  input wire clk_sys, // system clock
  input wire reset, // synchronous, active high
  input wire load, // restart with new count
  input wire [17:0] count, // cycles to wait
  output reg done // high while expired
);
  reg [17:0] cnt_r; // remaining cycles

  // count down to zero, then hold done high until reloaded
  always @(posedge clk_sys) begin
    if (reset) begin
      cnt_r <= 18'h00000;
      done <= 1'b0;
    end else if (load) begin
      cnt_r <= count;
      done <= 1'b0;
    end else if (cnt_r > 18'h00001) begin
      cnt_r <= cnt_r - 18'h00001;
    end else begin
      cnt_r <= 18'h00000;
      done <= 1'b1;
    end
  end
endmodule

// file: verification/drc_ctrl_checker.sv
/*
  checker: strobe order, init sequence and refresh spacing of drc_ctrl.
  assumes a single clk_sys domain with synchronous reset; bound below.
*/
`timescale 1ns/1ps
module drc_ctrl_checker #(
  parameter POWERUP_CYC = 20,
  parameter REF_INTERVAL_CYC = 200,
  parameter USE_CBR = 1
) (
  input wire clk_sys, // system clock
  input wire reset, // synchronous reset
  input wire ack, // access done
  input wire ready, // init done
  input wire row_strobe_n, // row strobe
  input wire col_strobe_n, // column strobe
  input wire write_strobe_n, // write strobe
  input wire oe_strobe_n, // output enable
  input wire data_pins_oe // data drive enable
);
  logic [31:0] up_cnt_r; // cycles since reset
  logic [3:0] dummy_r; // row falls before ready
  logic [31:0] ref_gap_r; // cycles since last counter refresh
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // helper counters; up_cnt_r and dummy_r saturate so a long run never wraps them
  always @(posedge clk_sys) begin
    if (reset) begin
      up_cnt_r <= 0;
      dummy_r <= 0;
      ref_gap_r <= 0;
    end else begin
      if (up_cnt_r != 32'hffffffff) up_cnt_r <= up_cnt_r + 1;
      if (!ready && $fell(row_strobe_n) && dummy_r != 4'hf) dummy_r <= dummy_r + 1;
      if ($fell(row_strobe_n) && !col_strobe_n) ref_gap_r <= 0;
      else ref_gap_r <= ref_gap_r + 1;
    end
  end
  powerup_wait_a: assert property (!row_strobe_n || !col_strobe_n |->
    up_cnt_r >= POWERUP_CYC)
    else $error("strobe moved before power-up wait");
  dummy_count_a: assert property ($rose(ready) |-> dummy_r >= 8)
    else $error("too few dummy cycles");
  init_quiet_a: assert property (!ready |-> write_strobe_n && !data_pins_oe)
    else $error("access during init");
  cbr_dummy_a: assert property (!ready && $fell(row_strobe_n) |-> USE_CBR == 0 || !col_strobe_n)
    else $error("dummy cycle not column first");
  read_hold_a: assert property (!oe_strobe_n && !col_strobe_n |-> write_strobe_n)
    else $error("write low during read");
  early_data_a: assert property ($fell(col_strobe_n) && !write_strobe_n |-> data_pins_oe)
    else $error("early write data late");
  rmw_data_a: assert property ($fell(write_strobe_n) && !col_strobe_n |-> data_pins_oe)
    else $error("late write data missing");
  write_window_a: assert property ($fell(col_strobe_n) && write_strobe_n && !row_strobe_n
    |-> write_strobe_n [*8])
    else $error("write fell in undefined region");
  float_oe_a: assert property (!oe_strobe_n |-> !data_pins_oe)
    else $error("data driven while output enabled");
  refresh_gap_a: assert property (ready |-> ref_gap_r <= REF_INTERVAL_CYC + 128)
    else $error("refresh interval exceeded");
  ack_pulse_a: assert property (ack |-> row_strobe_n && col_strobe_n ##1 !ack)
    else $error("ack not a released one-cycle pulse");
endmodule
bind drc_ctrl drc_ctrl_checker #(.POWERUP_CYC(POWERUP_CYC),
  .REF_INTERVAL_CYC(REF_INTERVAL_CYC), .USE_CBR(USE_CBR)) i_chk (.clk_sys(clk_sys),
  .reset(reset), .ack(ack), .ready(ready), .row_strobe_n(row_strobe_n),
  .col_strobe_n(col_strobe_n), .write_strobe_n(write_strobe_n), .oe_strobe_n(oe_strobe_n),
  .data_pins_oe(data_pins_oe));

// file: verification/drc_ctrl_tb.sv
/*
  self-checking bench for drc_ctrl against the behavioural dram model.
  assumes short power-up and refresh parameters; one clock, 4 ns period.
*/
`timescale 1ns/1ps
module drc_ctrl_tb;
  localparam int PWR_CYC = 60; // long enough that a skipped power-up wait shows
  localparam int REF_IVAL = 200; // shortened refresh spacing
  logic clk_sys = 0, reset = 1, req = 0; // clock, reset, request
  logic [1:0] req_kind = 0; // access kind
  logic [15:0] req_addr = 0; // row and column
  logic [3:0] req_wdata = 0; // write data
  wire ack, ready, rs_n, cs_n, ws_n, oe_n, pins_oe, m_drive; // dut and model outputs
  wire [3:0] rdata, pins_o, m_out, pins; // data paths
  wire [7:0] maddr; // multiplexed address
  int err_count = 0, total_checks = 0, seed = 66820, cyc = 0; // bookkeeping
  logic [3:0] exp_mem [0:65535]; // expected contents
  assign pins = pins_oe ? pins_o : m_out;
  always #2 clk_sys = ~clk_sys;
  drc_ctrl #(.POWERUP_CYC(PWR_CYC), .REF_INTERVAL_CYC(REF_IVAL), .USE_CBR(1)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .req(req), .req_kind(req_kind), .req_addr(req_addr),
    .req_wdata(req_wdata), .ack(ack), .rdata(rdata), .ready(ready), .row_strobe_n(rs_n),
    .col_strobe_n(cs_n), .write_strobe_n(ws_n), .oe_strobe_n(oe_n), .muxed_address(maddr),
    .data_pins_wr(pins_o), .data_pins_oe(pins_oe), .data_pins_rd(pins));
  drc_dram_model i_mem (.row_strobe_n(rs_n), .col_strobe_n(cs_n), .write_strobe_n(ws_n),
    .oe_strobe_n(oe_n), .muxed_address(maddr), .dq_bus(pins), .dq_val(m_out),
    .dq_drive(m_drive));
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // both parties driving the wire at once is a contention fault
  always @(posedge clk_sys) begin
    cyc++;
    if (m_drive && pins_oe) check("bus contention", 1, 0);
  end
  // hold the request until ack is sampled high, then release at that edge
  task access(input logic [1:0] k, input logic [15:0] a, input logic [3:0] d);
    int n;
    n = 0;
    req <= 1;
    req_kind <= k;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 2000);
    req <= 0;
    if (n >= 2000) begin
      check("ack timeout", 0, 1);
      final_report;
    end
    if (k == 2'd0) check("read data", rdata, exp_mem[a]);
    if (k == 2'd2) check("rmw old data", rdata, exp_mem[a]);
    if (k != 2'd0) exp_mem[a] = d;
    @(posedge clk_sys);
  endtask
  // bounded wait for init; the model counts the counter-refresh dummies
  task wait_ready;
    int n, c0;
    n = 0;
    c0 = i_mem.cbr_count;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ready !== 1'b1 && n < 5000);
    check("ready", ready, 1);
    if (n >= 5000) final_report;
    check("dummy refreshes", i_mem.cbr_count - c0, 8);
  endtask
  initial begin
    int n, c;
    for (int i = 0; i < 65536; i++) exp_mem[i] = 4'h0;
    repeat (3) @(posedge clk_sys);
    reset <= 0;
    wait_ready;
    access(2'd1, 16'h0000, 4'h5); // corner: lowest cell, back to back
    access(2'd0, 16'h0000, 4'h0);
    access(2'd2, 16'hffff, 4'ha);
    access(2'd0, 16'hffff, 4'h0);
    // mid-run reset: strobes released, init repeated, cells keep their data
    reset <= 1;
    repeat (3) @(posedge clk_sys);
    check("reset outputs", {ack, ready, rs_n, cs_n, ws_n, oe_n, pins_oe}, 7'h1e);
    reset <= 0;
    wait_ready;
    access(2'd0, 16'hffff, 4'h0);
    n = cyc;
    c = i_mem.cbr_count;
    for (int i = 0; i < 60; i++) begin
      access(2'($unsigned($random(seed)) % 3), 16'($random(seed)) & 16'h0f0f,
        4'($random(seed)));
      repeat ($unsigned($random(seed)) % 4) @(posedge clk_sys);
    end
    check("refresh rate", i_mem.cbr_count - c >= (cyc - n) / REF_IVAL - 1, 1);
    final_report;
  end
endmodule

// file: verification/drc_dram_model.sv
/*
  behavioural 64k x 4 multiplexed-address dram, reacting to strobe edges.
  assumes the bench resolves the shared data wire from the controller's drive enable alone.
*/
`timescale 1ns/1ps
module drc_dram_model (
  input wire row_strobe_n, // row strobe
  input wire col_strobe_n, // column strobe
  input wire write_strobe_n, // write strobe
  input wire oe_strobe_n, // output enable
  input wire [7:0] muxed_address, // multiplexed address
  input wire [3:0] dq_bus, // resolved data wire
  output logic [3:0] dq_val, // model value on the wire
  output logic dq_drive // high while driving
);
  logic [3:0] mem [0:65535]; // cell array
  logic [7:0] row_r; // latched row
  logic [15:0] addr_r = 0; // latched cell address
  logic early_r = 0, cbr_r = 0, acc_ok = 0; // cycle kind, access time met
  int cbr_count = 0; // counter refreshes seen
  realtime row_t = 0; // time of the latest row fall
  initial for (int i = 0; i < 65536; i++) mem[i] = 4'h0;
  // column low first means counter refresh: address ignored
  always @(negedge row_strobe_n) begin
    row_t = $realtime;
    cbr_r = !col_strobe_n;
    if (cbr_r) cbr_count++;
    else row_r = muxed_address;
  end
  // write low at column fall selects early write; data stored 1 ns after column fall
  always @(negedge col_strobe_n) if (!row_strobe_n && !cbr_r) begin
    addr_r = {row_r, muxed_address};
    early_r = !write_strobe_n;
    #1 if (early_r) mem[addr_r] = dq_bus;
    // column address is valid only at column fall, so its longer access governs
    #39;
    // row access still running: data waits for it as well
    if ($realtime - row_t < 80.0) #(80.0 - ($realtime - row_t));
    acc_ok = !col_strobe_n;
  end
  always @(posedge col_strobe_n) acc_ok = 0;
  // late write after a read phase stores new data (rmw)
  always @(negedge write_strobe_n) #1
    if (!row_strobe_n && !col_strobe_n && !cbr_r && !early_r) mem[addr_r] = dq_bus;
  // outputs stay off in early write and refresh; a released wire or one read
  // before access time shows the inverse, so a read without enable fails
  assign dq_drive = !row_strobe_n && !col_strobe_n && !oe_strobe_n && write_strobe_n
    && !early_r && !cbr_r;
  assign dq_val = (acc_ok && dq_drive) ? mem[addr_r] : ~mem[addr_r];
endmodule
